// ### hdl/power_stage_output_config.sv
`timescale 1ns/1ps
module power_stage_output_config #(
  parameter int UNITS = psu_pkg::NUM_UNITS,
  parameter int CW = psu_pkg::CNT_W
)
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [UNITS*CW-1:0] counter,
  input wire logic [UNITS-1:0] count_down,
  input wire logic [UNITS*2-1:0] mode,
  input wire logic [UNITS-1:0] fault_a,
  input wire logic [UNITS-1:0] fault_b,
  input wire logic [UNITS-1:0] retrigger,
  input wire logic [UNITS-1:0] capture,
  input wire logic [UNITS-1:0] sync_error,
  input wire logic [UNITS-1:0] wave_a,
  input wire logic [UNITS-1:0] wave_b,
  output logic [UNITS-1:0] adc_sync,
  output logic [UNITS*4-1:0] compare_match,
  output logic [UNITS*psu_pkg::FRAC_W-1:0] flank_fraction,
  output logic [UNITS-1:0] wave_out_a_pin,
  output logic [UNITS-1:0] wave_out_a_oe,
  output logic [UNITS-1:0] wave_out_b_pin,
  output logic [UNITS-1:0] wave_out_b_oe,
  output logic unit2_extra_pin_two,
  output logic unit2_extra_pin_two_oe,
  output logic unit2_extra_pin_three,
  output logic unit2_extra_pin_three_oe,
  output logic [psu_pkg::IRQ_W-1:0] irq_req,
  output logic [2:0] irq_vector
);
  logic [7:0] hi_latch_q;
  logic [7:0] hi_latch_d;
  logic [UNITS-1:0][7:0] cfg_q;
  logic [UNITS-1:0][CW-1:0] sa_q;
  logic [UNITS-1:0][CW-1:0] ra_q;
  logic [UNITS-1:0][CW-1:0] sb_q;
  logic [UNITS-1:0][CW-1:0] rb_q;
  logic [UNITS-1:0][psu_pkg::FRAC_W-1:0] frac_q;
  logic [UNITS-1:0][1:0] mask_q;
  logic [UNITS-1:0][1:0] flag_q;
  logic [UNITS-1:0][1:0] flag_d;
  logic [UNITS-1:0] m_rb;
  logic [UNITS-1:0][3:0] xo2;
  logic [31:0] rd_mux;
  logic [7:0] rd_byte;
  logic addr_ok;
  wire access = psel & penable;
  wire wr = access & pwrite;
  wire [1:0] unit_idx = paddr[7:6];
  wire [11:0] reg_ofs = {6'h00, paddr[5:0]};
  wire unit_ok = (32'(unit_idx) < UNITS) & (paddr[11:8] == 4'h0);
  wire [7:0] wbyte = pwdata[7:0];
  // Single-cycle slave; unmapped addresses answer with an error
  assign pready = psel & penable;
  assign pslverr = access & ~addr_ok;
  assign prdata = rd_mux;
  genvar g;
  generate
    for (g = 0; g < UNITS; g++)
    begin : g_unit
      wire sel_u = wr & unit_ok & (unit_idx == 2'(g));
      wire [CW-1:0] wval = {hi_latch_q[CW-9:0], wbyte};
      // Unit 2 alone keeps the extra output select bits
      wire [7:0] cmask = (g == 2) ? psu_pkg::CFG_U2_MASK
                                  : psu_pkg::CFG_U01_MASK;
      // A new event wins over a software clear in the same cycle
      assign flag_d[g][psu_pkg::F_EOC] = m_rb[g] | (flag_q[g][psu_pkg::F_EOC]
        & ~(sel_u & (reg_ofs == psu_pkg::OFS_FLAG)
        & pwdata[psu_pkg::F_EOC]));
      assign flag_d[g][psu_pkg::F_SNAP] = retrigger[g] | capture[g]
        | sync_error[g] | (flag_q[g][psu_pkg::F_SNAP]
        & ~(sel_u & (reg_ofs == psu_pkg::OFS_FLAG)
        & pwdata[psu_pkg::F_SNAP]));
      always_ff @(posedge clk_sys)
      begin
        if (reset)
        begin
          cfg_q[g] <= psu_pkg::CFG_RESET;
          sa_q[g] <= '0;
          ra_q[g] <= '0;
          sb_q[g] <= '0;
          rb_q[g] <= '0;
          frac_q[g] <= '0;
          mask_q[g] <= '0;
          flag_q[g] <= '0;
        end
        else
        begin
          flag_q[g] <= flag_d[g];
          if (sel_u)
          begin
            case (reg_ofs)
              psu_pkg::OFS_CFG: cfg_q[g] <= wbyte & cmask;
              psu_pkg::OFS_SA_LO: sa_q[g] <= wval;
              psu_pkg::OFS_RA_LO: ra_q[g] <= wval;
              psu_pkg::OFS_SB_LO: sb_q[g] <= wval;
              psu_pkg::OFS_RB_LO:
              begin
                rb_q[g] <= wval;
                frac_q[g] <= hi_latch_q[7:4];
              end
              psu_pkg::OFS_MASK: mask_q[g] <= wbyte[1:0];
              default: ;
            endcase
          end
        end
      end
      psu_unit #(.CW(CW), .EXTRA(g == 2)) u_unit (
        .clk_sys(clk_sys),
        .reset(reset),
        .cfg(cfg_q[g]),
        .set_a_compare(sa_q[g]),
        .reset_a_compare(ra_q[g]),
        .set_b_compare(sb_q[g]),
        .reset_b_compare(rb_q[g]),
        .counter(counter[g*CW +: CW]),
        .count_down(count_down[g]),
        .mode(psu_pkg::run_mode_t'(mode[g*2 +: 2])),
        .fault_a(fault_a[g]),
        .fault_b(fault_b[g]),
        .wave_a(wave_a[g]),
        .wave_b(wave_b[g]),
        .match_a_set(compare_match[g*4]),
        .match_a_reset(compare_match[g*4+1]),
        .match_b_set(compare_match[g*4+2]),
        .match_b_reset(m_rb[g]),
        .adc_sync(adc_sync[g]),
        .wave_out_a_pin(wave_out_a_pin[g]),
        .wave_out_a_oe(wave_out_a_oe[g]),
        .wave_out_b_pin(wave_out_b_pin[g]),
        .wave_out_b_oe(wave_out_b_oe[g]),
        .extra_pin_two(xo2[g][0]),
        .extra_pin_two_oe(xo2[g][1]),
        .extra_pin_three(xo2[g][2]),
        .extra_pin_three_oe(xo2[g][3])
      );
      assign compare_match[g*4+3] = m_rb[g];
      assign flank_fraction[g*psu_pkg::FRAC_W +: psu_pkg::FRAC_W] = frac_q[g];
      // Two requests per unit, highest unit in the low index
      assign irq_req[(UNITS-1-g)*2] = flag_q[g][psu_pkg::F_SNAP]
        & mask_q[g][psu_pkg::F_SNAP];
      assign irq_req[(UNITS-1-g)*2+1] = flag_q[g][psu_pkg::F_EOC]
        & mask_q[g][psu_pkg::F_EOC];
    end
  endgenerate
  assign unit2_extra_pin_two = xo2[UNITS-1][0];
  assign unit2_extra_pin_two_oe = xo2[UNITS-1][1];
  assign unit2_extra_pin_three = xo2[UNITS-1][2];
  assign unit2_extra_pin_three_oe = xo2[UNITS-1][3];
  // Fixed priority: lowest request index wins, vector 1 to 6, 0 for none
  always_comb
  begin
    irq_vector = 3'h0;
    for (int i = psu_pkg::IRQ_W - 1; i >= 0; i--)
    begin
      if (irq_req[i])
        irq_vector = 3'(i + 1);
    end
  end
  // Shared staging latch for every high byte
  wire hi_wr = wr & unit_ok & ((reg_ofs == psu_pkg::OFS_SA_HI)
    | (reg_ofs == psu_pkg::OFS_RA_HI) | (reg_ofs == psu_pkg::OFS_SB_HI)
    | (reg_ofs == psu_pkg::OFS_RB_HI));
  assign hi_latch_d = hi_wr ? wbyte : hi_latch_q;
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      hi_latch_q <= 8'h00;
    else
      hi_latch_q <= hi_latch_d;
  end
  // Read side; high bytes read back the stored compare high part
  always_comb
  begin
    rd_byte = 8'h00;
    addr_ok = unit_ok;
    if (unit_ok)
    begin
      case (reg_ofs)
        psu_pkg::OFS_CFG: rd_byte = cfg_q[unit_idx];
        psu_pkg::OFS_SA_LO: rd_byte = sa_q[unit_idx][7:0];
        psu_pkg::OFS_SA_HI: rd_byte = {4'h0, sa_q[unit_idx][CW-1:8]};
        psu_pkg::OFS_RA_LO: rd_byte = ra_q[unit_idx][7:0];
        psu_pkg::OFS_RA_HI: rd_byte = {4'h0, ra_q[unit_idx][CW-1:8]};
        psu_pkg::OFS_SB_LO: rd_byte = sb_q[unit_idx][7:0];
        psu_pkg::OFS_SB_HI: rd_byte = {4'h0, sb_q[unit_idx][CW-1:8]};
        psu_pkg::OFS_RB_LO: rd_byte = rb_q[unit_idx][7:0];
        psu_pkg::OFS_RB_HI: rd_byte = {frac_q[unit_idx],
                                       rb_q[unit_idx][CW-1:8]};
        psu_pkg::OFS_MASK: rd_byte = {6'h00, mask_q[unit_idx]};
        psu_pkg::OFS_FLAG: rd_byte = {6'h00, flag_q[unit_idx]};
        default: addr_ok = 1'b0;
      endcase
    end
    rd_mux = {24'h00_0000, rd_byte};
  end
endmodule : power_stage_output_config

// ### hdl/psu_pkg.sv
// How it works
// - Each unit has two interrupt sources: end-of-cycle and snapshot/error.
// - End-of-cycle request when counter matches reset-B compare value.
// - Snapshot/error request on retrigger, capture or mutual sync error.
// - Priority: unit 2 snapshot, unit 2 cycle end, then unit 1, unit 0.
// - Unit 2 extra output 3 select: 0 picks generator B, 1 picks A.
// - Unit 2 extra output 2 select: 0 picks generator A, 1 picks B.
// - Ramp modes: sync select picks edge of output A or B.
// - Centered: 00 reset-A match down, 01 up, 10/11 no sync.
// - Extra output 3 enable hands pin to selected generator.
// - Part B enable hands B pin to generator B.
// - Extra output 2 enable hands pin to selected generator.
// - Part A enable hands A pin to generator A.
// - Four 12-bit compare values compared continuously with counter.
// - A reset-B match can raise an interrupt; any match can pulse the ADC sync.
// - Reset-B compare also holds a 4-bit flank modulation fraction.
// - Compare writes stage high byte in one shared 8-bit latch.
// - Units 0 and 1 identical; unit 2 adds extra output bits.
package psu_pkg;
  localparam int NUM_UNITS = 3;
  localparam int CNT_W = 12;
  localparam int FRAC_W = 4;
  localparam int IRQ_W = 6;
  // Per-unit block of 64 bytes; byte offsets within a unit
  localparam logic [3:0] UNIT_SHIFT = 4'h4;
  localparam logic [11:0] OFS_CFG = 12'h000;
  localparam logic [11:0] OFS_SA_LO = 12'h004;
  localparam logic [11:0] OFS_SA_HI = 12'h008;
  localparam logic [11:0] OFS_RA_LO = 12'h00c;
  localparam logic [11:0] OFS_RA_HI = 12'h010;
  localparam logic [11:0] OFS_SB_LO = 12'h014;
  localparam logic [11:0] OFS_SB_HI = 12'h018;
  localparam logic [11:0] OFS_RB_LO = 12'h01c;
  localparam logic [11:0] OFS_RB_HI = 12'h020;
  localparam logic [11:0] OFS_MASK = 12'h024;
  localparam logic [11:0] OFS_FLAG = 12'h028;
  localparam logic [11:0] UNIT_STRIDE = 12'h040;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // Config bit positions
  localparam int B_EN_A = 0;
  localparam int B_EN_X2 = 1;
  localparam int B_EN_B = 2;
  localparam int B_EN_X3 = 3;
  localparam int B_SYNC_LO = 4;
  localparam int B_SEL_X2 = 6;
  localparam int B_SEL_X3 = 7;
  localparam logic [7:0] CFG_U01_MASK = 8'h3f;
  localparam logic [7:0] CFG_U2_MASK = 8'hff;
  // Flag and mask bit positions
  localparam int F_EOC = 0;
  localparam int F_SNAP = 1;
  typedef enum logic [1:0]
  {
    MODE_ONE = 2'b00,
    MODE_TWO = 2'b01,
    MODE_FOUR = 2'b10,
    MODE_CENTER = 2'b11
  } run_mode_t;
  typedef enum logic [1:0]
  {
    SYNC_LEAD_A = 2'b00,
    SYNC_TRAIL_A = 2'b01,
    SYNC_LEAD_B = 2'b10,
    SYNC_TRAIL_B = 2'b11
  } sync_sel_t;
endpackage : psu_pkg

// ### hdl/psu_unit.sv
`timescale 1ns/1ps
module psu_unit #(
  parameter int CW = 12,
  parameter bit EXTRA = 1'b0
)
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] cfg,
  input wire logic [CW-1:0] set_a_compare,
  input wire logic [CW-1:0] reset_a_compare,
  input wire logic [CW-1:0] set_b_compare,
  input wire logic [CW-1:0] reset_b_compare,
  input wire logic [CW-1:0] counter,
  input wire logic count_down,
  input wire psu_pkg::run_mode_t mode,
  input wire logic fault_a,
  input wire logic fault_b,
  input wire logic wave_a,
  input wire logic wave_b,
  output logic match_a_set,
  output logic match_a_reset,
  output logic match_b_set,
  output logic match_b_reset,
  output logic adc_sync,
  output logic wave_out_a_pin,
  output logic wave_out_a_oe,
  output logic wave_out_b_pin,
  output logic wave_out_b_oe,
  output logic extra_pin_two,
  output logic extra_pin_two_oe,
  output logic extra_pin_three,
  output logic extra_pin_three_oe
);
  logic sync_d;
  logic sync_q;
  logic x2_src;
  logic x3_src;
  wire [1:0] sel = cfg[psu_pkg::B_SYNC_LO +: 2];
  wire centered = (mode == psu_pkg::MODE_CENTER);
  // Continuous comparison of every compare value
  assign match_a_set = (counter == set_a_compare);
  assign match_a_reset = (counter == reset_a_compare);
  assign match_b_set = (counter == set_b_compare);
  assign match_b_reset = (counter == reset_b_compare);
  // Pins follow generators only when enabled, otherwise the port owns them
  assign wave_out_a_oe = cfg[psu_pkg::B_EN_A];
  assign wave_out_b_oe = cfg[psu_pkg::B_EN_B];
  assign x2_src = cfg[psu_pkg::B_SEL_X2] ? wave_b : wave_a;
  assign x3_src = cfg[psu_pkg::B_SEL_X3] ? wave_a : wave_b;
  // Extra pins exist only on unit 2
  assign extra_pin_two_oe = EXTRA & cfg[psu_pkg::B_EN_X2];
  assign extra_pin_three_oe = EXTRA & cfg[psu_pkg::B_EN_X3];
  always_comb
  begin
    case (sel)
      psu_pkg::SYNC_LEAD_A: sync_d = centered
        ? (match_a_reset & count_down) : match_a_set;
      psu_pkg::SYNC_TRAIL_A: sync_d = centered
        ? (match_a_reset & ~count_down)
        : (match_a_reset | fault_a);
      psu_pkg::SYNC_LEAD_B: sync_d = ~centered & match_b_set;
      psu_pkg::SYNC_TRAIL_B: sync_d = ~centered
        & (match_b_reset | fault_b);
      default: sync_d = 1'b0;
    endcase
  end
  // Registered outputs keep the pins glitch free
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      sync_q <= 1'b0;
      wave_out_a_pin <= 1'b0;
      wave_out_b_pin <= 1'b0;
      extra_pin_two <= 1'b0;
      extra_pin_three <= 1'b0;
    end
    else
    begin
      sync_q <= sync_d;
      wave_out_a_pin <= wave_a;
      wave_out_b_pin <= wave_b;
      extra_pin_two <= EXTRA & x2_src;
      extra_pin_three <= EXTRA & x3_src;
    end
  end
  assign adc_sync = sync_q;
endmodule : psu_unit

// ### testbench/psu_props.sv
`timescale 1ns/1ps
module psu_props #(
  parameter int UNITS = 3,
  parameter int CW = 12
)
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [UNITS*2-1:0] mode,
  input wire logic [UNITS-1:0] capture,
  input wire logic [UNITS-1:0] wave_a,
  input wire logic [UNITS-1:0] wave_b,
  input wire logic [UNITS-1:0] adc_sync,
  input wire logic [UNITS*4-1:0] compare_match,
  input wire logic [UNITS-1:0] wave_out_a_pin,
  input wire logic [UNITS-1:0] wave_out_a_oe,
  input wire logic [UNITS-1:0] wave_out_b_oe,
  input wire logic unit2_extra_pin_two,
  input wire logic unit2_extra_pin_two_oe,
  input wire logic unit2_extra_pin_three,
  input wire logic unit2_extra_pin_three_oe,
  input wire logic [psu_pkg::IRQ_W-1:0] irq_req,
  input wire logic [2:0] irq_vector
);
  logic [7:0] cfg0_q;
  logic [7:0] cfg2_q;
  logic [1:0] msk0_q;
  wire wr = psel && penable && pwrite;
  wire pick2 = cfg2_q[6] ? wave_b[2] : wave_a[2];
  wire pick3 = cfg2_q[7] ? wave_a[2] : wave_b[2];
  // Shadows of the registers, updated only by completed writes
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      cfg0_q <= 8'h00;
      cfg2_q <= 8'h00;
      msk0_q <= 2'h0;
    end
    else if (wr)
    begin
      if (paddr == 12'h000)
        cfg0_q <= pwdata[7:0];
      if (paddr == 12'h080)
        cfg2_q <= pwdata[7:0];
      if (paddr == 12'h024)
        msk0_q <= pwdata[1:0];
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  AST_PIN_A: assert property (
    wave_out_a_oe[0] == cfg0_q[0] &&
    ($past(reset) || wave_out_a_pin[0] == $past(wave_a[0])))
    else $error("pin a routing wrong");
  AST_OE_B: assert property (wave_out_b_oe[0] == cfg0_q[2])
    else $error("pin b enable wrong");
  AST_X2: assert property (
    unit2_extra_pin_two_oe == cfg2_q[1] &&
    ($past(reset) || unit2_extra_pin_two == $past(pick2)))
    else $error("extra pin two routing wrong");
  AST_X3: assert property (
    unit2_extra_pin_three_oe == cfg2_q[3] &&
    ($past(reset) || unit2_extra_pin_three == $past(pick3)))
    else $error("extra pin three routing wrong");
  // Vector names an active request and no higher priority one is pending
  AST_PRIO: assert property (
    (irq_vector == 3'h0) ? (irq_req == 6'h00)
    : (irq_req[irq_vector - 3'h1] &&
      (irq_req & ((6'h01 << (irq_vector - 3'h1)) - 6'h01)) == 6'h00))
    else $error("vector priority wrong");
  AST_SYNC_RAMP: assert property (
    !reset && mode[1:0] != 2'h3 && compare_match[cfg0_q[5:4]]
    |=> adc_sync[0])
    else $error("sync pulse missing");
  AST_SYNC_CTR: assert property (
    mode[1:0] == 2'h3 && cfg0_q[5] |=> !adc_sync[0])
    else $error("sync pulse in centered off code");
  AST_EOC: assert property (
    compare_match[3] && msk0_q[0] |-> ##[1:3] irq_req[5])
    else $error("end of cycle request missing");
  AST_SNAP: assert property (
    capture[0] && msk0_q[1] |-> ##[1:3] irq_req[4])
    else $error("snapshot request missing");
  AST_MASK: assert property (
    !msk0_q[0] && !$past(msk0_q[0]) && !$past(msk0_q[0], 2) |-> !irq_req[5])
    else $error("masked request raised");
endmodule : psu_props
bind power_stage_output_config psu_props #(.UNITS(UNITS), .CW(CW)) props (
  .clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .mode,
  .capture, .wave_a, .wave_b, .adc_sync, .compare_match, .wave_out_a_pin,
  .wave_out_a_oe, .wave_out_b_oe, .unit2_extra_pin_two,
  .unit2_extra_pin_two_oe, .unit2_extra_pin_three,
  .unit2_extra_pin_three_oe, .irq_req, .irq_vector);

// ### testbench/psu_switches.sv
`timescale 1ns/1ps
module psu_switches
(
  input wire logic clk_sys,
  input wire logic [2:0] gate_pin,
  input wire logic [2:0] gate_oe,
  input wire logic [2:0] adc_sync,
  output logic [2:0] gate_on,
  output int n_samples
);
  // A pin left as a plain port is not driven, so the switch stays off
  assign gate_on = gate_pin & gate_oe;
  initial n_samples = 0;
  always @(posedge clk_sys)
    if (adc_sync[0])
      n_samples <= n_samples + 1;
endmodule : psu_switches

// ### testbench/tb.sv
`timescale 1ns/1ps
`define CHK(n, e, a) \
  begin \
    n_checks++; \
    if ((a) !== (e)) \
    begin \
      n_fail++; \
      $display("unexpected %s exp %0h got %0h", n, e, a); \
    end \
  end
module tb;
  logic clk_sys, reset, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr, compare_match, flank_fraction;
  logic [31:0] pwdata, prdata, rdat;
  logic [35:0] counter;
  logic [5:0] mode, irq_req;
  logic [2:0] count_down, fault_a, fault_b, retrigger, capture, sync_error;
  logic [2:0] wave_a, wave_b, adc_sync, wave_out_a_pin, wave_out_a_oe;
  logic [2:0] wave_out_b_pin, wave_out_b_oe, irq_vector, gate_on;
  logic unit2_extra_pin_two, unit2_extra_pin_two_oe;
  logic unit2_extra_pin_three, unit2_extra_pin_three_oe;
  logic [11:0] tgt [4];
  int n_fail, n_checks, n_samples, k, j, x;
  power_stage_output_config uut (.clk_sys, .reset, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .counter, .count_down,
    .mode, .fault_a, .fault_b, .retrigger, .capture, .sync_error, .wave_a,
    .wave_b, .adc_sync, .compare_match, .flank_fraction, .wave_out_a_pin,
    .wave_out_a_oe, .wave_out_b_pin, .wave_out_b_oe, .unit2_extra_pin_two,
    .unit2_extra_pin_two_oe, .unit2_extra_pin_three,
    .unit2_extra_pin_three_oe, .irq_req, .irq_vector);
  psu_switches far (.clk_sys, .gate_pin(wave_out_a_pin),
    .gate_oe(wave_out_a_oe), .adc_sync, .gate_on, .n_samples);
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    rdat = prdata;
    rerr = pslverr;
    if (pready !== 1'b1)
    begin
      n_fail++;
      tally_and_finish;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task wcmp(input logic [11:0] a, input logic [15:0] v);
    apb(1'b1, a + 12'h004, {24'h00_0000, v[15:8]});
    apb(1'b1, a, {24'h00_0000, v[7:0]});
  endtask : wcmp
  task rd(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK("read", e, rdat[7:0])
  endtask : rd
  task hit(input logic [11:0] v);
    counter[11:0] <= v;
    cyc(1);
    counter[11:0] <= 12'h000;
    cyc(3);
  endtask : hit
  task pulse(input int e);
    {capture[2], sync_error[0], capture[0], retrigger[0]} <= 4'(1 << e);
    cyc(1);
    {capture[2], sync_error[0], capture[0], retrigger[0]} <= 4'h0;
    cyc(3);
  endtask : pulse
  initial
  begin
    reset = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, counter} = 83'h0;
    {mode, count_down, fault_a, fault_b, retrigger, capture} = 21'h0;
    {sync_error, wave_a, wave_b} = 9'h0;
    tgt = '{12'h111, 12'h567, 12'h333, 12'h821};
    cyc(8);
    reset <= 1'b0;
    cyc(1);
    rd(12'h000, 8'h00);
    apb(1'b1, 12'h040, 32'h0000_00ff);
    rd(12'h040, 8'h3f);
    apb(1'b0, 12'h0c0, 32'h0000_0000);
    `CHK("slverr", 1'b1, rerr)
    wave_a <= 3'h5;
    for (int s = 0; s < 4; s++)
    begin
      apb(1'b1, 12'h080, {24'h00_0000, 2'(s), 6'h0f});
      apb(1'b1, 12'h000, 32'((s & 1) * 5));
      cyc(2);
      `CHK("pin two", ~s[0], unit2_extra_pin_two)
      `CHK("pin three", s[1], unit2_extra_pin_three)
      `CHK("switch a", s[0], gate_on[0])
      `CHK("oe b", s[0], wave_out_b_oe[0])
    end
    rd(12'h080, 8'hcf);
    apb(1'b1, 12'h080, 32'h0000_0000);
    `CHK("oe x", 2'h0,
      {unit2_extra_pin_two_oe, unit2_extra_pin_three_oe})
    wave_b <= 3'h7;
    cyc(2);
    `CHK("pin b", 3'h7, wave_out_b_pin)
    wcmp(12'h004, 16'h0111);
    wcmp(12'h00c, 16'h0567);
    wcmp(12'h014, 16'h0333);
    wcmp(12'h01c, 16'ha821);
    rd(12'h010, 8'h05);
    `CHK("fraction", 4'ha, flank_fraction[3:0])
    counter[11:0] <= 12'h567;
    cyc(1);
    `CHK("match", 4'h2, compare_match[3:0])
    apb(1'b1, 12'h010, 32'h0000_0002);
    apb(1'b1, 12'h054, 32'h0000_0022);
    counter[23:0] <= 24'h222_566;
    cyc(1);
    `CHK("match", 8'h40, compare_match[7:0])
    counter[23:0] <= 24'h000_000;
    for (int m = 0; m < 4; m++)
    begin
      mode[1:0] <= 2'(m);
      for (int c = 0; c < 4; c++)
      begin
        apb(1'b1, 12'h000, 32'(c << 4));
        for (int t = 0; t < 4; t++)
        begin
          count_down[0] <= t[0];
          j = n_samples;
          hit(tgt[m == 3 ? 1 : t]);
          x = (m < 3) ? (c == t) : (c == 0 && t[0]) || (c == 1 && !t[0]);
          `CHK("sync", x, n_samples - j)
        end
      end
    end
    mode[1:0] <= 2'h0;
    j = n_samples;
    fault_b[0] <= 1'b1;
    cyc(1);
    fault_b[0] <= 1'b0;
    cyc(3);
    `CHK("fault sync", 1, n_samples - j)
    apb(1'b1, 12'h024, 32'h0000_0003);
    hit(tgt[3]);
    `CHK("eoc", 4'he, {irq_req[5], irq_vector})
    for (int e = 0; e < 3; e++)
    begin
      apb(1'b1, 12'h028, 32'h0000_0003);
      pulse(e);
      `CHK("snap", 5'h0d, {irq_req[5:4], irq_vector})
    end
    apb(1'b1, 12'h0a4, 32'h0000_0002);
    pulse(3);
    `CHK("vector", 3'h1, irq_vector)
    apb(1'b1, 12'h024, 32'h0000_0000);
    apb(1'b1, 12'h028, 32'h0000_0003);
    pulse(2);
    `CHK("masked", 1'b0, irq_req[4])
    rd(12'h028, 8'h02);
    tally_and_finish;
  end
endmodule : tb
